// [hdl/xbar_map.vh]
// register indices, field positions and reset values of the port crossbar
`ifndef XBAR_MAP_VH
`define XBAR_MAP_VH

// register indices; byte address is four times the index
`define IDX_PSEL0        10'h0e1
`define IDX_PSEL1        10'h0e2
`define IDX_IN_MODE      10'h000
`define IDX_OUT_MODE     10'h008
`define IDX_SKIP         10'h010
`define IDX_LATCH        10'h018
`define IDX_PIN_STATE    10'h020

// peripheral_select_reg0 fields
`define F_CMP1_ASYNC     7
`define F_CMP1           6
`define F_CMP0_ASYNC     5
`define F_CMP0           4
`define F_SYSTEM_CLOCK_OUT_OUT     3
`define F_TWO_WIRE       2
`define F_SPI            1
`define F_UART_A         0

// peripheral_select_reg1 fields
`define F_WEAK_PUD       7
`define F_ROUTE_EN       6

// spi slave select mode value meaning 3-wire operation
`define SSM_THREE_WIRE   2'h0

// fixed pins of uart a
`define PIN_UART_A_TX    5'h04
`define PIN_UART_A_RX    5'h05

// reset values
`define RST_PSEL         8'h00
`define RST_IN_MODE      8'hff
`define RST_OUT_MODE     8'h00
`define RST_SKIP         8'h00
`define RST_LATCH        8'hff

// routed signal slots in priority order
`define SIG_NUM          11
`define SIG_NONE         4'hf
`define SIG_SDA          4'h4
`define SIG_SCL          4'h5

`endif

// [hdl/pin_cell.v]
// one port pin: output stage, pull-up control and input synchroniser
`timescale 1ns/1ps
`default_nettype none

module pin_cell (
  input  wire pclk,
  input  wire presetn,
  input  wire value,
  input  wire oe_req,
  input  wire open_drain,
  input  wire analog,
  input  wire pullup_dis,
  input  wire pin_in,
  output reg  pin_out,
  output reg  pin_oe,
  output reg  pin_pullup,
  output reg  rx_en,
  output wire pin_sync
);

  reg  sync1_reg;
  reg  sync2_reg;
  wire drv_oe;
  wire drv_out;

  // open-drain only pulls low, push-pull drives both levels
  assign drv_oe  = ~analog & oe_req & (~open_drain | ~value);
  assign drv_out = open_drain ? 1'b0 : value;

  // registered driver controls
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out    <= 1'b0;
      pin_oe     <= 1'b0;
      pin_pullup <= 1'b0;
      rx_en      <= 1'b1;
    end else begin
      pin_out    <= drv_out;
      pin_oe     <= drv_oe;
      // pull-up on open-drain; off while driving low
      pin_pullup <= open_drain & ~pullup_dis & ~analog & ~(drv_oe & ~drv_out);
      rx_en      <= ~analog;
    end
  end

  // two-flop synchroniser of the pad level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  assign pin_sync = sync2_reg & rx_en;

endmodule // pin_cell

`default_nettype wire

// [hdl/io_crossbar.v]
// priority crossbar and port configuration with an apb register slave
//
// Function
// - two-wire bus routing always takes both data and clock pins together.
// - uart routing always takes transmit and receive pins as a pair.
// - uart a transmit sits on P0.4 and receive on P0.5, always.
// - plain port pins follow contiguously once routed functions are placed.
// - spi slave select gets a pin only in 4-wire mode.
// - analog pins lose pull-up, digital driver and digital receiver.
// - input mode bit 1 is digital, 0 analog; reset gives digital.
// - output mode bit picks open-drain or push-pull, routed pins too.
// - two-wire bus pins are always open-drain.
// - pull-up disable 0 enables pull-ups on open-drain pins only.
// - pull-up is off while the pin drives low.
// - until routing is enabled port 0 to 3 pins are plain port pins in input mode.
// - with routing disabled ports 0 to 3 have drivers off.
// - port 4 bypasses the crossbar and is always plain port.
// - select bits 7..4 route comparator 1/0 async and sync outputs.
// - select bits 3..0 route clock out, two-wire, spi, uart a.
// - each selected signal in priority order takes the lowest free pin.
// - skipped pins count as assigned and are passed over.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "xbar_map.vh"

module io_crossbar (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  input  wire [1:0]  slave_select_mode_field,
  input  wire        uart_a_transmit,
  output reg         uart_a_receive,
  input  wire [10:0] route_out,
  input  wire [10:0] route_oe,
  output reg  [10:0] route_in,
  input  wire [39:0] pin_in,
  output wire [39:0] pin_out,
  output wire [39:0] pin_oe,
  output wire [39:0] pin_pullup,
  output wire [39:0] pin_rx_en
);

  //--------------------------------------------------------------------
  // registers
  //--------------------------------------------------------------------
  reg  [7:0]  peripheral_select_reg0;
  reg  [7:0]  peripheral_select_reg1;
  reg  [7:0]  pin_input_mode_reg [0:4];
  reg  [7:0]  pin_output_mode_reg [0:4];
  reg  [7:0]  pin_skip_reg [0:3];
  reg  [7:0]  port_latch_reg [0:4];

  wire [9:0]  idx;
  wire [2:0]  sub;
  wire        in_range;
  wire        wr_en;
  wire        rd_setup;
  reg  [7:0]  rd_next;
  reg         rd_hit;
  wire [39:0] pin_sync;
  wire [39:0] in_mode_flat;
  wire [39:0] out_mode_flat;
  wire [31:0] skip_flat;
  wire [39:0] latch_flat;
  wire        routing_enable;
  wire        weak_pullup_disable;
  integer     i;

  assign idx      = paddr[11:2];
  assign sub      = idx[2:0];
  assign in_range = (idx[9:6] == 4'h0) && (sub < 3'h5);
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready   = psel & penable;
  assign pslverr  = psel & penable & ~rd_hit;

  assign routing_enable      = peripheral_select_reg1[`F_ROUTE_EN];
  assign weak_pullup_disable = peripheral_select_reg1[`F_WEAK_PUD];

  // address decode: hit flag and read value
  always @* begin
    rd_hit  = 1'b0;
    rd_next = 8'h00;
    if (idx == `IDX_PSEL0) begin
      rd_hit  = 1'b1;
      rd_next = peripheral_select_reg0;
    end else if (idx == `IDX_PSEL1) begin
      rd_hit  = 1'b1;
      rd_next = peripheral_select_reg1;
    end else if (in_range) begin
      case ({idx[5:3], 3'h0})
        6'h00: begin
          rd_hit  = 1'b1;
          rd_next = pin_input_mode_reg[sub];
        end
        6'h08: begin
          rd_hit  = 1'b1;
          rd_next = pin_output_mode_reg[sub];
        end
        6'h10: begin
          rd_hit  = (sub != 3'h4);
          rd_next = (sub != 3'h4) ? pin_skip_reg[sub[1:0]] : 8'h00;
        end
        6'h18: begin
          rd_hit  = 1'b1;
          rd_next = port_latch_reg[sub];
        end
        6'h20: begin
          rd_hit  = 1'b1;
          rd_next = pin_sync[sub*8 +: 8];
        end
        default: begin
          rd_hit  = 1'b0;
          rd_next = 8'h00;
        end
      endcase
    end
  end

  // register writes in the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_select_reg0 <= `RST_PSEL;
      peripheral_select_reg1 <= `RST_PSEL;
      for (i = 0; i < 5; i = i + 1) begin
        // pins leave reset as digital inputs
        pin_input_mode_reg[i]  <= `RST_IN_MODE;
        pin_output_mode_reg[i] <= `RST_OUT_MODE;
        port_latch_reg[i]      <= `RST_LATCH;
      end
      for (i = 0; i < 4; i = i + 1) begin
        pin_skip_reg[i] <= `RST_SKIP;
      end
    end else if (wr_en && rd_hit) begin
      if (idx == `IDX_PSEL0) begin
        peripheral_select_reg0 <= pwdata[7:0];
      end else if (idx == `IDX_PSEL1) begin
        peripheral_select_reg1 <= pwdata[7:0];
      end else if (idx[5:3] == 3'h0) begin
        pin_input_mode_reg[sub] <= pwdata[7:0];
      end else if (idx[5:3] == 3'h1) begin
        pin_output_mode_reg[sub] <= pwdata[7:0];
      end else if (idx[5:3] == 3'h2) begin
        pin_skip_reg[sub[1:0]] <= pwdata[7:0];
      end else if (idx[5:3] == 3'h3) begin
        port_latch_reg[sub] <= pwdata[7:0];
      end
    end
  end

  // read data captured in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= {24'h000000, rd_next};
    end
  end

  //--------------------------------------------------------------------
  // priority decoder
  //--------------------------------------------------------------------
  reg  [10:0] sig_req;
  reg  [31:0] free_pin;
  reg  [3:0]  pin_sel [0:31];
  reg  [5:0]  rank;
  reg  [5:0]  seen;
  reg  [39:0] drv_val;
  reg  [39:0] drv_oe;
  reg  [39:0] force_od;
  reg  [10:0] route_in_next;
  reg         uart_rx_next;
  wire        uart_on;
  integer     p;
  integer     k;
  integer     q;           // pin loop of the rank search, kept apart from p

  assign uart_on = peripheral_select_reg0[`F_UART_A];

  // flattened per-pin configuration
  genvar g;
  generate
    for (g = 0; g < 40; g = g + 1) begin : g_flat
      assign in_mode_flat[g]  = pin_input_mode_reg[g/8][g%8];
      assign out_mode_flat[g] = pin_output_mode_reg[g/8][g%8];
      assign latch_flat[g]    = port_latch_reg[g/8][g%8];
      if (g < 32) begin : g_skip
        assign skip_flat[g] = pin_skip_reg[g/8][g%8];
      end
    end
  endgenerate

  // selected signals in priority order and free pin mask
  always @* begin
    // spi, two-wire bus, comparator and clock out select bits
    // slave select only in 4-wire mode
    sig_req[0] = peripheral_select_reg0[`F_SPI];
    sig_req[1] = peripheral_select_reg0[`F_SPI];
    sig_req[2] = peripheral_select_reg0[`F_SPI];
    sig_req[3] = peripheral_select_reg0[`F_SPI] &
                 (slave_select_mode_field != `SSM_THREE_WIRE);
    sig_req[4] = peripheral_select_reg0[`F_TWO_WIRE];
    sig_req[5] = peripheral_select_reg0[`F_TWO_WIRE];
    sig_req[6] = peripheral_select_reg0[`F_CMP0];
    sig_req[7] = peripheral_select_reg0[`F_CMP0_ASYNC];
    sig_req[8] = peripheral_select_reg0[`F_CMP1];
    sig_req[9] = peripheral_select_reg0[`F_CMP1_ASYNC];
    sig_req[10] = peripheral_select_reg0[`F_SYSTEM_CLOCK_OUT_OUT];
    free_pin = ~skip_flat;
    // uart a pins reserved whatever the skip bits
    if (uart_on) begin
      free_pin[`PIN_UART_A_TX] = 1'b0;
      free_pin[`PIN_UART_A_RX] = 1'b0;
    end
  end

  // n-th free pin goes to n-th selected signal
  // mapping is pure logic of register contents and slave_select_mode_field
  always @* begin
    rank = 6'h00;
    seen = 6'h00;
    for (q = 0; q < 32; q = q + 1) begin
      pin_sel[q] = `SIG_NONE;
      if (free_pin[q]) begin
        seen = 6'h00;
        for (k = 0; k < `SIG_NUM; k = k + 1) begin
          if (sig_req[k]) begin
            if (seen == rank) begin
              pin_sel[q] = k[3:0];
            end
            seen = seen + 6'h01;
          end
        end
        rank = rank + 6'h01;
      end
    end
  end

  // per-pin drive value, enable request and forced open-drain
  always @* begin
    route_in_next = {`SIG_NUM{1'b1}};
    uart_rx_next  = 1'b1;
    for (p = 0; p < 40; p = p + 1) begin
      // unrouted pins are plain port pins
      drv_val[p]  = latch_flat[p];
      drv_oe[p]   = 1'b1;
      force_od[p] = 1'b0;
      if (p < 32) begin
        if (uart_on && p == `PIN_UART_A_TX) begin
          // uart transmit and receive as a pair
          drv_val[p] = uart_a_transmit;
        end else if (uart_on && p == `PIN_UART_A_RX) begin
          drv_val[p]   = 1'b1;
          drv_oe[p]    = 1'b0;
          uart_rx_next = pin_sync[p];
        end else if (pin_sel[p] != `SIG_NONE) begin
          drv_val[p] = route_out[pin_sel[p]];
          drv_oe[p]  = route_oe[pin_sel[p]];
          force_od[p] = (pin_sel[p] == `SIG_SDA) || (pin_sel[p] == `SIG_SCL);
          route_in_next[pin_sel[p]] = pin_sync[p];
        end
        // disabled crossbar gives plain input pins
        // ports 0 to 3 drivers off while disabled
        if (!routing_enable) begin
          drv_val[p]  = latch_flat[p];
          drv_oe[p]   = 1'b0;
          force_od[p] = 1'b0;
        end
      end
    end
    // no peripheral sees a pin until enabled
    if (!routing_enable) begin
      route_in_next = {`SIG_NUM{1'b1}};
      uart_rx_next  = 1'b1;
    end
  end

  // registered receive paths towards the peripherals
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_in       <= {`SIG_NUM{1'b1}};
      uart_a_receive <= 1'b1;
    end else begin
      route_in       <= route_in_next;
      uart_a_receive <= uart_rx_next;
    end
  end

  //--------------------------------------------------------------------
  // pin cells
  //--------------------------------------------------------------------
  // port 4 pins take latch and modes with no crossbar gating
  generate
    for (g = 0; g < 40; g = g + 1) begin : g_pin
      pin_cell u_cell (
        .pclk       (pclk),
        .presetn    (presetn),
        .value      (drv_val[g]),
        .oe_req     (drv_oe[g]),
        // output mode bit chooses the driver type
        .open_drain (~out_mode_flat[g] | force_od[g]),
        // input mode bit 0 means analog
        .analog     (~in_mode_flat[g]),
        .pullup_dis (weak_pullup_disable),
        .pin_in     (pin_in[g]),
        .pin_out    (pin_out[g]),
        .pin_oe     (pin_oe[g]),
        .pin_pullup (pin_pullup[g]),
        .rx_en      (pin_rx_en[g]),
        .pin_sync   (pin_sync[g])
      );
    end
  endgenerate

endmodule // io_crossbar

`default_nettype wire

// [verif/io_crossbar_sva.sv]
// pin-level assertions on the port crossbar
`timescale 1ns/1ps
`default_nettype none
`include "xbar_map.vh"
module io_crossbar_sva (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pslverr,
  input wire [10:0] route_in,
  input wire [39:0] pin_out,
  input wire [39:0] pin_oe,
  input wire [39:0] pin_pullup,
  input wire [39:0] pin_rx_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // decoded register writes
  wire wr     = psel && penable && pwrite;
  wire sel1_w = wr && paddr[11:2] == `IDX_PSEL1;
  analog_off_a: assert property ((~pin_rx_en & (pin_pullup | pin_oe)) == 40'h0)
    else $error("analog pin still active");
  low_pullup_a: assert property ((pin_oe & ~pin_out & pin_pullup) == 40'h0)
    else $error("pull-up on while driving low");
  pp_pullup_a: assert property ((pin_oe & pin_out & pin_pullup) == 40'h0)
    else $error("pull-up on push-pull pin");
  rst_state_a: assert property ($rose(presetn) |-> pin_rx_en == {40{1'b1}} && pin_oe == 40'h0)
    else $error("pads wrong after reset");
  xbar_off_a: assert property (sel1_w && !pwdata[6] |-> ##2 pin_oe[31:0] == 32'h0)
    else $error("driver on with routing off");
  pud_off_a: assert property (sel1_w && pwdata[7] |-> ##2 pin_pullup == 40'h0)
    else $error("pull-up left on");
  slot_unroute_a: assert property (sel1_w && !pwdata[6] |-> ##[1:4] route_in == 11'h7ff)
    else $error("slot still routed");
  in_mode_a: assert property (wr && paddr[11:2] == `IDX_IN_MODE
    |-> ##2 pin_rx_en[7:0] == $past(pwdata[7:0], 2))
    else $error("receiver enable mismatch");
  cover property (sel1_w && pwdata[6]);
  cover property (pslverr);
  cover property (pin_oe[4] && !pin_out[4]);
endmodule // io_crossbar_sva
bind io_crossbar io_crossbar_sva io_crossbar_sva_inst (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pslverr, .route_in, .pin_out, .pin_oe, .pin_pullup, .pin_rx_en);
`default_nettype wire

// [verif/board_pads.sv]
// board-side model of the port pads
`timescale 1ns/1ps
`default_nettype none
module board_pads (
  input  wire logic        pclk,
  input  wire logic [39:0] pin_out,
  input  wire logic [39:0] pin_oe,
  input  wire logic [39:0] pin_pullup,
  input  wire logic [39:0] ext_en,
  input  wire logic [39:0] ext_val,
  output logic      [39:0] pin_in
);
  logic [39:0] flt = 40'h0;
  // a floating pad without pull-up wanders every cycle
  always @(posedge pclk) begin
    flt <= ~flt;
  end
  // pad level from design driver, board driver and pull-up
  always_comb begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
      | (~pin_oe & ~ext_en & (pin_pullup | flt));
  end
endmodule // board_pads
`default_nettype wire

// [verif/test_io_crossbar.sv]
// self-checking bench for the port crossbar
`timescale 1ns/1ps
`default_nettype none
`include "xbar_map.vh"
module test_io_crossbar;
  logic        pclk, presetn, psel, penable, pwrite, uart_a_transmit, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [1:0]  slave_select_mode_field;
  logic [10:0] route_out, route_oe;
  logic [39:0] ext_en, ext_val;
  wire         pready, pslverr, uart_a_receive;
  wire  [31:0] prdata;
  wire  [10:0] route_in;
  wire  [39:0] pin_in, pin_out, pin_oe, pin_pullup, pin_rx_en;
  int          err_total = 0;
  int          total_checks = 0;
  logic [9:0]  idx [7] = '{`IDX_PSEL0, `IDX_PSEL1, `IDX_IN_MODE, `IDX_OUT_MODE, `IDX_SKIP,
                          `IDX_LATCH, 10'h014};
  logic [7:0]  rst [7] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00};
  io_crossbar io_crossbar_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .prdata, .slave_select_mode_field, .uart_a_transmit, .uart_a_receive,
    .route_out, .route_oe, .route_in, .pin_in, .pin_out, .pin_oe, .pin_pullup, .pin_rx_en);
  board_pads board_pads_inst (.pclk, .pin_out, .pin_oe, .pin_pullup, .ext_en, .ext_val, .pin_in);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // ------------------------------------------------------------
  // bus access, compare, settle and verdict
  // ------------------------------------------------------------
  task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 2'b00, 24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) err_total++;
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic look(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic conclude;
    if (err_total == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {uart_a_transmit, slave_select_mode_field, route_out, ext_en, ext_val} = '0;
    route_oe = 11'h7ff;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      apb(0, idx[i], 8'h00);
      chk("reset value", rd, rst[i]);
      chk("slave error", er, i == 6);
    end
    look(0);
    chk("drivers off", pin_oe, 40'h0);
    chk("reset pull-ups", pin_pullup, {40{1'b1}});
    apb(1, `IDX_IN_MODE, 8'hbf);
    apb(1, `IDX_OUT_MODE, 8'hff);
    apb(1, `IDX_SKIP, 8'h40);
    apb(1, `IDX_PSEL0, 8'h04);
    route_out <= 11'h020;
    apb(1, `IDX_PSEL1, 8'h40);
    look(1);
    chk("drive enables", pin_oe[7:0], 8'hbd);
    chk("drive levels", pin_out[7:0] & pin_oe[7:0], 8'hbc);
    chk("low pull-up", pin_pullup[1:0], 2'b10);
    chk("analog pin", {pin_rx_en[6], pin_pullup[6]}, 2'b00);
    apb(1, `IDX_SKIP, 8'h41);
    ext_en <= 40'h20;
    apb(1, `IDX_PSEL0, 8'h05);
    look(4);
    chk("uart pins", {pin_oe[4], pin_out[4], uart_a_receive}, 3'b100);
    chk("moved pair", {pin_oe[2:0], pin_out[2:0] & pin_oe[2:0]}, 6'b011001);
    chk("pair inputs", route_in[5:4], 2'b10);
    apb(1, `IDX_PSEL0, 8'h12);
    route_out <= 11'h002;
    for (int m = 0; m < 2; m++) begin
      @(posedge pclk);
      slave_select_mode_field <= 2'(m);
      look(1);
      chk("slave select", pin_out[5:4] & pin_oe[5:4], m ? 2'b00 : 2'b10);
      chk("priority order", pin_out[3:1] & pin_oe[3:1], 3'b010);
    end
    apb(1, `IDX_SKIP, 8'h00);
    for (int b = 0; b < 8; b++) begin
      apb(1, `IDX_PSEL0, 8'h01 << b);
      look(1);
      chk("select bit", {pin_out[4], pin_out[0]}, b ? 2'b10 : 2'b01);
    end
    apb(0, `IDX_PSEL0, 8'h00);
    chk("select read", rd, 32'h80);
    apb(1, `IDX_LATCH, 8'hfb);
    apb(1, `IDX_LATCH + 10'h4, 8'hfe);
    apb(1, `IDX_OUT_MODE + 10'h4, 8'h01);
    apb(1, `IDX_PSEL1, 8'h80);
    look(1);
    chk("ports off", pin_oe[31:0], 32'h0);
    chk("port four", {pin_oe[32], pin_out[32]}, 2'b10);
    chk("pull-ups off", pin_pullup, 40'h0);
    apb(1, `IDX_PSEL1, 8'h40);
    look(0);
    chk("one cycle later", pin_oe[2], 1'b0);
    look(1);
    chk("gpio drive", {pin_oe[2], pin_out[2], pin_pullup[33]}, 3'b101);
    conclude;
  end
  // watchdog against a hung handshake
  initial begin
    repeat (3000) @(posedge pclk);
    err_total++;
    conclude;
  end
endmodule // test_io_crossbar
`default_nettype wire
